// ---- src/lar_cfg.svh ----
// Purpose: timing and layout constants of the readout sequencer
// Assumes: one core clock at 100 MHz
// Notes: counts are in section-clock edges, not core cycles
`ifndef LAR_CFG_SVH
`define LAR_CFG_SVH

// stages per section shift register
`define LAR_STAGES 768
// section-clock edges of integrator reset after start capture
`define LAR_RST_CLKS 18
// width of the per-section edge counter and pixel index
`define LAR_CW 11
// number of sections
`define LAR_NSEC 2
// synchroniser reset level
`define LAR_SYNC_RST 1'b0

`endif

// ---- src/lar_pkg.sv ----
// Purpose: types shared by the readout sequencer files
// Assumes: lar_cfg.svh gives widths
// Notes: state is one packed struct, registered as a whole
`include "lar_cfg.svh"

package lar_pkg;

  // gray codes along idle -> read -> tail; tail -> idle flips both bits
  typedef enum logic [1:0] {
    LAR_IDLE = 2'h0,
    LAR_READ = 2'h1,
    LAR_TAIL = 2'h3
  } lar_state_t;

  typedef struct packed {
    lar_state_t [`LAR_NSEC-1:0] st;
    logic [`LAR_NSEC-1:0][`LAR_CW-1:0] cnt;
    logic [`LAR_NSEC-1:0][`LAR_CW-1:0] idx;
    logic [`LAR_NSEC-1:0] oe;
    logic [`LAR_NSEC-1:0] tok;
    logic [`LAR_NSEC-1:0] irst;
    logic [`LAR_NSEC-1:0] hold_stb;
  } lar_regs_t;

endpackage

// ---- src/lar_pin_sync.sv ----
// Purpose: two-flop synchroniser with rising-edge detect for pins
// Assumes: pins are asynchronous to core_clk
// Notes: prev is one core cycle older than level
`timescale 1ns/1ps
`include "lar_cfg.svh"

module lar_pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] prev,
  output logic [W-1:0] rise
);

  logic [W-1:0] meta_r;
  logic [W-1:0] level_r;
  logic [W-1:0] prev_r;

  initial begin
    if (W < 1) $error("lar_pin_sync: W must be at least 1");
  end

  // first flop feeds only the second
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_r <= {W{`LAR_SYNC_RST}};
      level_r <= {W{`LAR_SYNC_RST}};
      prev_r <= {W{`LAR_SYNC_RST}};
    end else begin
      meta_r <= pin_in;
      level_r <= meta_r;
      prev_r <= level_r;
    end
  end

  assign level = level_r;
  assign prev = prev_r;
  assign rise = level_r & ~prev_r;

endmodule

// ---- src/lar_sequencer.sv ----
// Purpose: readout sequencer for a two-section linear photodiode array
// Assumes: section clocks, starts and holds are pins from a controller
// Notes: analog levels are external; this block drives selects and enables
`timescale 1ns/1ps
`include "lar_cfg.svh"

module lar_sequencer
  import lar_pkg::*;
#(
  parameter int PIXELS = `LAR_STAGES,
  parameter int RESET_CLKS = `LAR_RST_CLKS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic section1_clock,
  input wire logic section2_clock,
  input wire logic section1_start_in,
  input wire logic section2_start_in,
  input wire logic section1_hold_in,
  input wire logic section2_hold_in,
  output logic section1_token_out,
  output logic section2_token_out,
  output logic section1_pixel_out_en,
  output logic section2_pixel_out_en,
  output logic [`LAR_CW-1:0] section1_pixel_index,
  output logic [`LAR_CW-1:0] section2_pixel_index,
  output logic section1_integ_reset,
  output logic section2_integ_reset,
  output logic section1_sample_hold,
  output logic section2_sample_hold
);

  localparam int NS = `LAR_NSEC;
  localparam logic [`LAR_CW-1:0] PIX_C = `LAR_CW'(PIXELS);
  localparam logic [`LAR_CW-1:0] LAST_C = `LAR_CW'(PIXELS - 1);
  localparam logic [`LAR_CW-1:0] PRE_C = `LAR_CW'(PIXELS - 2);
  localparam logic [`LAR_CW-1:0] RST_C = `LAR_CW'(RESET_CLKS);
  localparam logic [`LAR_CW-1:0] RST_LAST_C = `LAR_CW'(RESET_CLKS - 1);

  initial begin
    if (PIXELS < 2 || PIXELS + 1 >= (1 << `LAR_CW))
      $error("lar_sequencer: PIXELS out of counter range");
    if (RESET_CLKS < 1 || RESET_CLKS >= PIXELS)
      $error("lar_sequencer: RESET_CLKS must lie below PIXELS");
  end

  logic [NS-1:0] clk_lvl;
  logic [NS-1:0] clk_prev;
  logic [NS-1:0] clk_rise;
  logic [NS-1:0] start_lvl;
  logic [NS-1:0] start_prev;
  logic [NS-1:0] hold_lvl;
  logic [NS-1:0] hold_prev;
  logic [NS-1:0] hold_rise;

  lar_regs_t cur_r;
  lar_regs_t cur_nxt;

  lar_pin_sync #(
    .W(NS)
  ) u_clk_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in({section2_clock, section1_clock}),
    .level(clk_lvl),
    .prev(clk_prev),
    .rise(clk_rise)
  );

  // start is read one core cycle before the edge shows, so a start that
  // drops right after the section edge is still seen as high
  lar_pin_sync #(
    .W(NS)
  ) u_start_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in({section2_start_in, section1_start_in}),
    .level(start_lvl),
    .prev(start_prev),
    .rise()
  );

  lar_pin_sync #(
    .W(NS)
  ) u_hold_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in({section2_hold_in, section1_hold_in}),
    .level(hold_lvl),
    .prev(hold_prev),
    .rise(hold_rise)
  );

  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.hold_stb = '0;
    for (int s = 0; s < NS; s++) begin
      if (hold_rise[s]) begin
        cur_nxt.hold_stb[s] = 1'b1;
      end
      if (clk_rise[s]) begin
        case (cur_r.st[s])
          LAR_IDLE: begin
            // each section takes its own start
            if (start_prev[s]) begin
              cur_nxt.st[s] = LAR_READ;
              cur_nxt.cnt[s] = '0;
              cur_nxt.idx[s] = '0;
              cur_nxt.oe[s] = 1'b1;
              cur_nxt.irst[s] = 1'b1;
            end
          end
          LAR_READ: begin
            cur_nxt.cnt[s] = cur_r.cnt[s] + `LAR_CW'(1);
            if (cur_r.cnt[s] == RST_LAST_C) begin
              cur_nxt.irst[s] = 1'b0;
            end
            // token rides with the last pixel, so a chained section
            // takes it on the following edge and no clock is lost
            if (cur_r.cnt[s] == PRE_C) begin
              cur_nxt.tok[s] = 1'b1;
              cur_nxt.st[s] = LAR_TAIL;
            end
            cur_nxt.idx[s] = cur_r.cnt[s] + `LAR_CW'(1);
          end
          LAR_TAIL: begin
            cur_nxt.cnt[s] = cur_r.cnt[s] + `LAR_CW'(1);
            cur_nxt.tok[s] = 1'b0;
            cur_nxt.oe[s] = 1'b0;
            cur_nxt.st[s] = LAR_IDLE;
          end
          default: begin
            cur_nxt.st[s] = LAR_IDLE;
            cur_nxt.oe[s] = 1'b0;
            cur_nxt.tok[s] = 1'b0;
            cur_nxt.irst[s] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign section1_token_out = cur_r.tok[0];
  assign section2_token_out = cur_r.tok[1];
  assign section1_pixel_out_en = cur_r.oe[0];
  assign section2_pixel_out_en = cur_r.oe[1];
  assign section1_pixel_index = cur_r.idx[0];
  assign section2_pixel_index = cur_r.idx[1];
  assign section1_integ_reset = cur_r.irst[0];
  assign section2_integ_reset = cur_r.irst[1];
  assign section1_sample_hold = cur_r.hold_stb[0];
  assign section2_sample_hold = cur_r.hold_stb[1];

  default clocking lar_cb @(posedge core_clk);
  endclocking

  default disable iff (sys_rst);

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_chk
      a_start_opens: assert property (
        cur_r.st[g] == LAR_IDLE && clk_rise[g] && start_prev[g]
        |=> cur_r.oe[g] && cur_r.irst[g] && cur_r.idx[g] == '0
      ) else $error("start capture did not open readout");

      a_busy_ignore: assert property (
        cur_r.st[g] == LAR_READ && clk_rise[g]
        |=> cur_r.cnt[g] == $past(cur_r.cnt[g]) + `LAR_CW'(1)
      ) else $error("readout counter restarted while busy");

      a_reset_len: assert property (
        $fell(cur_r.irst[g]) |-> cur_r.cnt[g] == RST_C
      ) else $error("integrator reset ended at wrong edge");

      a_reset_ends: assert property (
        cur_r.st[g] == LAR_READ && clk_rise[g] && cur_r.cnt[g] == RST_LAST_C
        |=> !cur_r.irst[g]
      ) else $error("integrator reset held too long");

      a_pixel_step: assert property (
        cur_r.st[g] == LAR_READ && clk_rise[g] && cur_r.cnt[g] != LAST_C
        |=> cur_r.idx[g] == $past(cur_r.idx[g]) + `LAR_CW'(1)
      ) else $error("pixel index did not advance by one");

      a_token_rise: assert property (
        $rose(cur_r.tok[g]) |-> cur_r.cnt[g] == LAST_C
          && cur_r.idx[g] == LAST_C
      ) else $error("token rose at wrong stage");

      a_token_ends: assert property (
        cur_r.tok[g] && clk_rise[g] |=> !cur_r.tok[g] && !cur_r.oe[g]
      ) else $error("token or output outlived next clock");

      a_idle_hiz: assert property (
        cur_r.st[g] == LAR_IDLE |-> !cur_r.oe[g] && !cur_r.tok[g]
      ) else $error("idle section drives output");

      a_own_clock: assert property (
        !clk_rise[g] |=> $stable(cur_r.cnt[g]) && $stable(cur_r.st[g])
      ) else $error("section moved without its clock");

      a_hold_pulse: assert property (
        hold_rise[g] |=> cur_r.hold_stb[g] ##1 !cur_r.hold_stb[g]
      ) else $error("hold strobe not a single pulse");

      a_tail_count: assert property (
        $fell(cur_r.oe[g]) |-> cur_r.cnt[g] == PIX_C
      ) else $error("output released at wrong count");

      a_token_tail: assert property (
        $rose(cur_r.tok[g]) |-> cur_r.st[g] == LAR_TAIL
      ) else $error("token rose outside tail state");

      a_hold_only: assert property (
        !hold_rise[g] |=> !cur_r.hold_stb[g]
      ) else $error("hold strobe without hold rise");

      a_tail_idle: assert property (
        cur_r.st[g] == LAR_TAIL && clk_rise[g] |=> cur_r.st[g] == LAR_IDLE
      ) else $error("tail state outlived its edge");

      a_index_range: assert property (
        cur_r.idx[g] <= LAST_C
      ) else $error("pixel index beyond last stage");

      a_start_low: assert property (
        cur_r.st[g] == LAR_IDLE && clk_rise[g] && !start_prev[g]
        |=> cur_r.st[g] == LAR_IDLE
      ) else $error("section left idle without start");

      a_reset_inside: assert property (
        cur_r.irst[g] |-> cur_r.st[g] == LAR_READ
      ) else $error("integrator reset outside readout");

      a_token_oe: assert property (
        cur_r.tok[g] |-> cur_r.oe[g]
      ) else $error("token high with output released");
    end
  endgenerate

endmodule

// ---- test/lar_ctrl_model.sv ----
// Purpose: controller model for one section: clock, start and hold pins
// Assumes: pins change 1 ns after a core_clk edge
// Notes: one step is 150 ns, clock idles low between steps
`timescale 1ns/1ps

module lar_ctrl_model #(
  // charge_transfer_delay in core cycles, shrunk like the stage count
  parameter int XFER_CYC = 30
) (
  input wire logic core_clk,
  output logic sec_clock,
  output logic start_in,
  output logic hold_in
);
  initial begin
    sec_clock = 1'b0;
    start_in = 1'b0;
    hold_in = 1'b0;
  end

  task automatic wait_c(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // hold tied to start, single clock
  // slow clock, start set up 50 ns early
  // transfer time before a new start
  task automatic xfer_wait();
    wait_c(XFER_CYC);
  endtask

  // next start left to the caller
  task automatic step(input logic s);
    start_in = s;
    hold_in = s;
    wait_c(5);
    sec_clock = 1'b1;
    wait_c(6);
    sec_clock = 1'b0;
    wait_c(4);
  endtask
endmodule

// ---- test/lar_sequencer_tb.sv ----
// Purpose: self-checking bench of the readout sequencer
// Assumes: stages shrunk to 16, reset count to 4
// Notes: outputs are judged 100 ns after each section edge
`timescale 1ns/1ps
`include "lar_cfg.svh"

module lar_sequencer_tb;
  import lar_pkg::*;
  localparam int P = 16;
  localparam int R = 4;
  logic core_clk;
  logic sys_rst;
  logic serial;
  logic c1_clk, c1_start, c1_hold, c2_clk, c2_start, c2_hold;
  logic tok1, tok2, oe1, oe2, irst1, irst2, sh1, sh2;
  logic [`LAR_CW-1:0] idx1, idx2;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int hold_cnt1 = 0;
  int hold_cnt2 = 0;

  lar_ctrl_model u_c1 (.core_clk(core_clk), .sec_clock(c1_clk),
    .start_in(c1_start), .hold_in(c1_hold));
  lar_ctrl_model u_c2 (.core_clk(core_clk), .sec_clock(c2_clk),
    .start_in(c2_start), .hold_in(c2_hold));

  // serial mode: board chains token one into start two
  lar_sequencer #(.PIXELS(P), .RESET_CLKS(R)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .section1_clock(c1_clk),
    .section2_clock(serial ? c1_clk : c2_clk),
    .section1_start_in(c1_start),
    .section2_start_in(serial ? tok1 : c2_start),
    .section1_hold_in(c1_hold),
    .section2_hold_in(serial ? c1_start : c2_hold),
    .section1_token_out(tok1), .section2_token_out(tok2),
    .section1_pixel_out_en(oe1), .section2_pixel_out_en(oe2),
    .section1_pixel_index(idx1), .section2_pixel_index(idx2),
    .section1_integ_reset(irst1), .section2_integ_reset(irst2),
    .section1_sample_hold(sh1), .section2_sample_hold(sh2)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (sh1 === 1'b1) hold_cnt1 <= hold_cnt1 + 1;
    if (sh2 === 1'b1) hold_cnt2 <= hold_cnt2 + 1;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [10:0] seen,
                       input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // k counts section edges since capture; negative means idle
  task automatic chk_sec(input int sec, input int k);
    logic [10:0] oe, tok, irst, idx;
    oe = 11'(sec == 1 ? oe1 : oe2);
    tok = 11'(sec == 1 ? tok1 : tok2);
    irst = 11'(sec == 1 ? irst1 : irst2);
    idx = sec == 1 ? idx1 : idx2;
    check("pixel_out_en", oe, 11'(k >= 0 && k < P));
    check("token_out", tok, 11'(k == P - 1));
    check("integ_reset", irst, 11'(k >= 0 && k < R));
    if (k >= 0 && k < P)
      check("pixel_index", idx, 11'(k));
  endtask

  // start on the tail edge is ignored, then a fresh readout
  task automatic sc_single();
    int h;
    h = hold_cnt1;
    for (int k = 0; k <= P + 2; k++) begin
      u_c1.step(k == 0 || k == P);
      chk_sec(1, k);
      chk_sec(2, -1);
    end
    u_c1.xfer_wait();
    for (int k = 0; k <= P + 1; k++) begin
      u_c1.step(k == 0);
      chk_sec(1, k);
    end
    check("hold_pulses1", 11'(hold_cnt1 - h), 11'h003);
  endtask

  task automatic sc_parallel();
    int h;
    h = hold_cnt2;
    for (int k = 0; k <= P + 1; k++) begin
      u_c2.step(k == 0);
      chk_sec(2, k);
      chk_sec(1, -1);
    end
    check("hold_pulses2", 11'(hold_cnt2 - h), 11'h001);
  endtask

  // section two captures the token one edge after it rises
  task automatic sc_serial();
    int h;
    h = hold_cnt2;
    serial = 1'b1;
    for (int k = 0; k <= 2 * P + 1; k++) begin
      u_c1.step(k == 0);
      chk_sec(1, k);
      chk_sec(2, k - P);
    end
    check("hold_pulses2", 11'(hold_cnt2 - h), 11'h001);
    serial = 1'b0;
  endtask

  task automatic summarize();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    serial = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    sc_single();
    sc_parallel();
    sc_serial();
    summarize();
  end
endmodule
